// *** mrhf_top.sv ***
`timescale 1ns/1ps
`include "mrhf_defs.svh"
module mrhf_top (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        da_valid_i,
    input  wire logic        da_sof_i,
    input  wire logic [7:0]  da_byte_i,
    output logic             da_ready_o,
    output logic             res_valid_o,
    output logic             res_accept_o,
    output logic             res_group_o,
    output logic             res_exact_o,
    output logic [5:0]       res_hash_o,
    input  wire logic        res_ready_i,
    input  wire logic [10:0] tx_level_i,
    output logic             tx_start_ok_o,
    output logic [10:0]      tx_fifo_last_o,
    output logic [10:0]      rx_fifo_first_o,
    output logic [10:0]      rx_fifo_last_o,
    output logic [31:0]      rx_ring_base_o
);

    logic [31:0]          unicast_hash_upper_reg;
    logic [31:0]          unicast_hash_lower_reg;
    logic [31:0]          multicast_hash_upper_reg;
    logic [31:0]          multicast_hash_lower_reg;
    logic [1:0]           tx_start_watermark_reg;
    logic [7:0]           rx_fifo_start_reg;
    logic [29:0]          rx_ring_base_reg;
    logic [31:0]          station_address_low_reg;
    logic [15:0]          station_address_high_reg;
    logic [31:0]          prdata_reg;
    logic [31:0]          rd_value;
    logic                 addr_hit;
    logic                 setup_rd;
    logic                 wr_en;
    logic [10:0]          wm_bytes;
    mrhf_pkg::mrhf_state_t state_reg;
    logic [2:0]           byte_cnt_reg;
    logic [31:0]          crc_reg;
    logic [47:0]          da_reg;
    logic                 da_take;
    logic [5:0]           hash_idx;
    logic                 is_group;
    logic                 exact_hit;
    logic                 uc_hit;
    logic                 mc_hit;
    logic                 push_ready;
    mrhf_pkg::mrhf_result_t push_word;

    ////////////////////////////////////////////////////////////////////////
    // Merge write data under the APB byte strobes.
    function automatic logic [31:0] apply_strb(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] result;
        result = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                result[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return result;
    endfunction : apply_strb

    // Pick one bit of a 64-entry table split over two words.
    function automatic logic hash_lookup(
        input logic [31:0] upper,
        input logic [31:0] lower,
        input logic [5:0]  idx
    );
        logic [63:0] table_bits;
        table_bits = {upper, lower};
        return table_bits[idx];
    endfunction : hash_lookup

    // Advance the reflected Ethernet CRC by one byte, low bit first.
    function automatic logic [31:0] crc_byte(
        input logic [31:0] crc_in,
        input logic [7:0]  data
    );
        logic [31:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++)
        begin
            c = (c[0] ^ data[i]) ? ((c >> 1) ^ `MRHF_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

    ////////////////////////////////////////////////////////////////////////
    // APB decode. No wait states; the setup cycle prepares the read data.
    assign pready_o = psel_i & penable_i;
    assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
    assign wr_en    = psel_i & penable_i & pwrite_i & addr_hit;
    assign pslverr_o = psel_i & penable_i & ~addr_hit;
    assign prdata_o = prdata_reg;

    // Read multiplexer; reserved bits come back as zero.
    always_comb
    begin
        addr_hit = 1'b1;
        rd_value = 32'h00000000;
        unique case (paddr_i)
            `MRHF_OFF_UC_HASH_HI: rd_value = unicast_hash_upper_reg;
            `MRHF_OFF_UC_HASH_LO: rd_value = unicast_hash_lower_reg;
            `MRHF_OFF_MC_HASH_HI: rd_value = multicast_hash_upper_reg;
            `MRHF_OFF_MC_HASH_LO: rd_value = multicast_hash_lower_reg;
            `MRHF_OFF_TX_WMARK:
                rd_value[`MRHF_WM_MSB:0] = tx_start_watermark_reg;
            `MRHF_OFF_RAM_BOUND:
            begin
                rd_value[`MRHF_ADDR_MSB:`MRHF_ADDR_LSB] =
                    `MRHF_RAM_BOUND_VAL;
                rd_value[`MRHF_FIXED_ONE_BIT] = 1'b1;
            end
            `MRHF_OFF_RX_START:
            begin
                rd_value[`MRHF_ADDR_MSB:`MRHF_ADDR_LSB] = rx_fifo_start_reg;
                rd_value[`MRHF_FIXED_ONE_BIT] = 1'b1;
            end
            `MRHF_OFF_RX_RING:    rd_value = {rx_ring_base_reg, 2'b00};
            `MRHF_OFF_STN_LOW:    rd_value = station_address_low_reg;
            `MRHF_OFF_STN_HIGH:
                rd_value = {station_address_high_reg, `MRHF_PAUSE_TYPE};
            default:              addr_hit = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_reg <= 32'h00000000;
        end
        else if (setup_rd)
        begin
            prdata_reg <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tables, ring base and station address are unreset: X until written.
    always_ff @(posedge mclk_i)
    begin
        if (wr_en && paddr_i == `MRHF_OFF_UC_HASH_HI)
        begin
            unicast_hash_upper_reg <= apply_strb(unicast_hash_upper_reg,
                                                 pwdata_i, pstrb_i);
        end
        if (wr_en && paddr_i == `MRHF_OFF_UC_HASH_LO)
        begin
            unicast_hash_lower_reg <= apply_strb(unicast_hash_lower_reg,
                                                 pwdata_i, pstrb_i);
        end
        if (wr_en && paddr_i == `MRHF_OFF_MC_HASH_HI)
        begin
            multicast_hash_upper_reg <= apply_strb(multicast_hash_upper_reg,
                                                   pwdata_i, pstrb_i);
        end
        if (wr_en && paddr_i == `MRHF_OFF_MC_HASH_LO)
        begin
            multicast_hash_lower_reg <= apply_strb(multicast_hash_lower_reg,
                                                   pwdata_i, pstrb_i);
        end
    end

    // Ring base keeps bits 31 to 2; the low two bits are dropped.
    always_ff @(posedge mclk_i)
    begin
        if (wr_en && paddr_i == `MRHF_OFF_RX_RING)
        begin
            rx_ring_base_reg <= 30'(apply_strb({rx_ring_base_reg, 2'b00},
                                           pwdata_i, pstrb_i) >> 2);
        end
    end

    // Station address for the exact match; the type field is constant.
    always_ff @(posedge mclk_i)
    begin
        if (wr_en && paddr_i == `MRHF_OFF_STN_LOW)
        begin
            station_address_low_reg <= apply_strb(station_address_low_reg,
                                                  pwdata_i, pstrb_i);
        end
        if (wr_en && paddr_i == `MRHF_OFF_STN_HIGH)
        begin
            station_address_high_reg <= 16'(apply_strb(
                {station_address_high_reg, 16'h0000}, pwdata_i,
                pstrb_i) >> `MRHF_STN_HIGH_LSB);
        end
    end

    // Watermark and receive start have reset values.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_start_watermark_reg <= `MRHF_WM_RST;
            rx_fifo_start_reg      <= `MRHF_RX_START_RST;
        end
        else
        begin
            if (wr_en && paddr_i == `MRHF_OFF_TX_WMARK && pstrb_i[0])
            begin
                tx_start_watermark_reg <= pwdata_i[`MRHF_WM_MSB:0];
            end
            // Only the address field is stored; bit 10 is wired high.
            if (wr_en && paddr_i == `MRHF_OFF_RX_START && pstrb_i[0] &&
                pstrb_i[1])
            begin
                rx_fifo_start_reg <=
                    pwdata_i[`MRHF_ADDR_MSB:`MRHF_ADDR_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start threshold; a deeper one trades latency for underrun margin.
    always_comb
    begin
        unique case (tx_start_watermark_reg)
            2'h2:    wm_bytes = `MRHF_WM_BYTES_MID;
            2'h3:    wm_bytes = `MRHF_WM_BYTES_HIGH;
            default: wm_bytes = `MRHF_WM_BYTES_LOW;
        endcase
    end
    assign tx_start_ok_o = (tx_level_i >= wm_bytes);

    // FIFO RAM partition; bit 10 is always set in both receive bound addresses.
    assign rx_fifo_first_o = {1'b1, rx_fifo_start_reg, 2'b00};
    assign tx_fifo_last_o  = rx_fifo_first_o - `MRHF_RAM_STEP;
    assign rx_fifo_last_o  = {1'b1, `MRHF_RAM_BOUND_VAL, 2'b00};
    assign rx_ring_base_o  = {rx_ring_base_reg, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Address collector; input stalls while a verdict waits for FIFO room.
    assign da_ready_o = (state_reg == mrhf_pkg::MRHF_COLLECT);
    assign da_take    = da_valid_i & da_ready_o;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg    <= mrhf_pkg::MRHF_COLLECT;
            byte_cnt_reg <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                mrhf_pkg::MRHF_COLLECT:
                begin
                    if (da_take)
                    begin
                        if (da_sof_i)
                        begin
                            byte_cnt_reg <= 3'h1;
                        end
                        else if (byte_cnt_reg == `MRHF_DA_BYTES - 3'h1)
                        begin
                            byte_cnt_reg <= 3'h0;
                            state_reg    <= mrhf_pkg::MRHF_RESULT;
                        end
                        else
                        begin
                            byte_cnt_reg <= byte_cnt_reg + 3'h1;
                        end
                    end
                end
                mrhf_pkg::MRHF_RESULT:
                begin
                    if (push_ready)
                    begin
                        state_reg <= mrhf_pkg::MRHF_COLLECT;
                    end
                end
            endcase
        end
    end

    // CRC and address shift; a start byte restarts the CRC, the address register just shifts it in.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            crc_reg <= `MRHF_CRC_INIT;
            da_reg  <= 48'h000000000000;
        end
        else if (da_take)
        begin
            crc_reg <= crc_byte(da_sof_i ? `MRHF_CRC_INIT : crc_reg,
                                da_byte_i);
            da_reg  <= {da_reg[39:0], da_byte_i};
        end
    end

    // Verdict. First address byte low bit marks a group address.
    assign hash_idx  = crc_reg[31:26];
    assign is_group  = da_reg[40];
    assign exact_hit = (da_reg == {station_address_low_reg,
                                   station_address_high_reg});
    assign uc_hit    = hash_lookup(unicast_hash_upper_reg,
                                   unicast_hash_lower_reg,
                                   hash_idx);
    assign mc_hit    = hash_lookup(multicast_hash_upper_reg,
                                   multicast_hash_lower_reg,
                                   hash_idx);

    always_comb
    begin
        push_word.accept = is_group ? mc_hit : (exact_hit | uc_hit);
        push_word.group  = is_group;
        push_word.exact  = exact_hit & ~is_group;
        push_word.hash   = hash_idx;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdicts queue here so the consumer may lag by up to four frames.
    mrhf_fifo #(
        .WIDTH ($bits(mrhf_pkg::mrhf_result_t)),
        .DEPTH (4)
    ) u_result_fifo (
        .clk_i       (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (state_reg == mrhf_pkg::MRHF_RESULT),
        .in_data_i   (push_word),
        .in_ready_o  (push_ready),
        .out_valid_o (res_valid_o),
        .out_data_o  ({res_accept_o, res_group_o, res_exact_o, res_hash_o}),
        .out_ready_i (res_ready_i)
    );

endmodule : mrhf_top

// *** mrhf_defs.svh ***
`ifndef MRHF_DEFS_SVH
`define MRHF_DEFS_SVH

// Register byte offsets on the APB.
`define MRHF_OFF_UC_HASH_HI   12'h000
`define MRHF_OFF_UC_HASH_LO   12'h004
`define MRHF_OFF_MC_HASH_HI   12'h008
`define MRHF_OFF_MC_HASH_LO   12'h00c
`define MRHF_OFF_TX_WMARK     12'h010
`define MRHF_OFF_RAM_BOUND    12'h014
`define MRHF_OFF_RX_START     12'h018
`define MRHF_OFF_RX_RING      12'h01c
`define MRHF_OFF_STN_LOW      12'h020
`define MRHF_OFF_STN_HIGH     12'h024

// Field positions.
`define MRHF_WM_MSB           1
`define MRHF_ADDR_MSB         9
`define MRHF_ADDR_LSB         2
`define MRHF_FIXED_ONE_BIT    10
`define MRHF_STN_HIGH_LSB     16

// Reset and constant values.
`define MRHF_WM_RST           2'h0
`define MRHF_RX_START_RST     8'h40
`define MRHF_RAM_BOUND_VAL    8'hff
`define MRHF_PAUSE_TYPE       16'h8808

// Transmit start thresholds in bytes.
`define MRHF_WM_BYTES_LOW     11'h040
`define MRHF_WM_BYTES_MID     11'h080
`define MRHF_WM_BYTES_HIGH    11'h0c0

// Destination address handling and the FIFO RAM step.
`define MRHF_DA_BYTES         3'h6
`define MRHF_CRC_INIT         32'hffffffff
`define MRHF_CRC_POLY         32'hedb88320
`define MRHF_RAM_STEP         11'h004

`endif

// *** mrhf_pkg.sv ***
package mrhf_pkg;

    // Filter sequencer states, one-hot.
    typedef enum logic [1:0] {
        MRHF_COLLECT = 2'b01,
        MRHF_RESULT  = 2'b10
    } mrhf_state_t;

    // One filter verdict as it sits in the result FIFO.
    typedef struct packed {
        logic       accept;
        logic       group;
        logic       exact;
        logic [5:0] hash;
    } mrhf_result_t;

endpackage : mrhf_pkg

// *** mrhf_fifo.sv ***
`timescale 1ns/1ps
module mrhf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Flags come straight from the occupancy count.
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg];

    // Storage needs no reset; only the count and pointers decide what is valid.
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers wrap at the depth, so non power of two depths also work.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 :
                              wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 :
                              rd_ptr_reg + 1'b1;
            end
        end
    end

    // Occupancy follows push and pop together.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
        end
        else if (push && !pop)
        begin
            count_reg <= count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule : mrhf_fifo

// *** mrhf_top_asserts.sv ***
`timescale 1ns/1ps
module mrhf_chk (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        da_valid_i,
    input  wire logic        da_sof_i,
    input  wire logic        da_ready_o,
    input  wire logic        res_valid_o,
    input  wire logic        res_accept_o,
    input  wire logic        res_group_o,
    input  wire logic        res_exact_o,
    input  wire logic [10:0] tx_level_i,
    input  wire logic        tx_start_ok_o,
    input  wire logic [10:0] tx_fifo_last_o,
    input  wire logic [10:0] rx_fifo_first_o,
    input  wire logic [10:0] rx_fifo_last_o,
    input  wire logic [31:0] rx_ring_base_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [1:0]  wm_reg;
    logic [10:0] thr;
    logic        wr;
    ////////////////////////////////////////////////////////////////////////
    // Watermark shadow, so the threshold is known every cycle.
    assign wr = psel_i && penable_i && pwrite_i;
    always_ff @(posedge mclk_i or posedge rst_i)
        if (rst_i)
            wm_reg <= 2'h0;
        else if (wr && paddr_i == 12'h010 && pstrb_i[0])
            wm_reg <= pwdata_i[1:0];
    assign thr = wm_reg[1] ? (wm_reg[0] ? 11'h0c0 : 11'h080) : 11'h040;
    // Six address bytes taken on consecutive edges, first one marked.
    sequence first_s;
        da_valid_i && da_sof_i && da_ready_o;
    endsequence
    sequence frame_s;
        first_s ##1 (da_valid_i && da_ready_o) [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ready_zero_wait_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("no pready");
    bound_read_a: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == 12'h014
        |=> prdata_o == 32'h000007fc) else $error("bound read wrong");
    rx_bound_out_a: assert property (rx_fifo_last_o == 11'h7fc)
        else $error("rx end wrong");
    tx_region_end_a: assert property (
        tx_fifo_last_o == rx_fifo_first_o - 11'h004)
        else $error("tx end wrong");
    rx_start_reset_a: assert property (
        $fell(rst_i) |-> rx_fifo_first_o == 11'h500)
        else $error("rx start not reset");
    tx_threshold_a: assert property (
        tx_start_ok_o == (tx_level_i >= thr))
        else $error("threshold wrong");
    ring_base_wr_a: assert property (
        wr && paddr_i == 12'h01c && pstrb_i == 4'hf
        |=> rx_ring_base_o == ($past(pwdata_i) & 32'hfffffffc))
        else $error("ring base wrong");
    verdict_pause_a: assert property (frame_s |=> !da_ready_o)
        else $error("no pause after frame");
    verdict_push_a: assert property (
        $rose(res_valid_o) |-> !$past(da_ready_o))
        else $error("verdict without a frame");
    group_no_exact_a: assert property (
        res_valid_o && res_group_o |-> !res_exact_o)
        else $error("exact flag on group frame");
    exact_accept_a: assert property (
        res_valid_o && !res_group_o && res_exact_o |-> res_accept_o)
        else $error("exact match not accepted");
endmodule : mrhf_chk

bind mrhf_top mrhf_chk u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .da_valid_i(da_valid_i), .da_sof_i(da_sof_i),
    .da_ready_o(da_ready_o), .res_valid_o(res_valid_o),
    .res_accept_o(res_accept_o), .res_group_o(res_group_o),
    .res_exact_o(res_exact_o), .tx_level_i(tx_level_i),
    .tx_start_ok_o(tx_start_ok_o), .tx_fifo_last_o(tx_fifo_last_o),
    .rx_fifo_first_o(rx_fifo_first_o), .rx_fifo_last_o(rx_fifo_last_o),
    .rx_ring_base_o(rx_ring_base_o)
);

// *** mrhf_sink.sv ***
`timescale 1ns/1ps
module mrhf_sink (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    output logic      res_ready_o
);
    int seed = 29;
    // Verdict consumer that hesitates at random, so pops are irregular.
    always_ff @(posedge mclk_i or posedge rst_i)
        if (rst_i)
            res_ready_o <= 1'b0;
        else
            res_ready_o <= !stall_i && ($random(seed) % 3 != 0);
endmodule : mrhf_sink

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        mclk_i = 1'b0, rst_i = 1'b1, stall = 1'b0, er, res_ready;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic        da_valid_i = 1'b0, da_sof_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, rd, v, val[7];
    logic [7:0]  da_byte_i = 8'h00;
    logic [10:0] tx_level_i = 11'h000, t;
    logic [47:0] stn;
    logic [31:0] prdata_o, rx_ring_base_o;
    logic [10:0] tx_fifo_last_o, rx_fifo_first_o, rx_fifo_last_o;
    logic [5:0]  res_hash_o;
    logic        pready_o, pslverr_o, da_ready_o, res_valid_o, tx_start_ok_o;
    logic        res_accept_o, res_group_o, res_exact_o;
    logic [8:0]  exp_q[$];
    logic [11:0] offs[7] = '{12'h000, 12'h004, 12'h008, 12'h00c,
                             12'h01c, 12'h020, 12'h024};
    int          fail_count = 0, checks = 0, seed = 29, n;

    always #2 mclk_i = ~mclk_i;

    mrhf_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .da_valid_i(da_valid_i),
        .da_sof_i(da_sof_i), .da_byte_i(da_byte_i), .da_ready_o(da_ready_o),
        .res_valid_o(res_valid_o), .res_accept_o(res_accept_o),
        .res_group_o(res_group_o), .res_exact_o(res_exact_o),
        .res_hash_o(res_hash_o), .res_ready_i(res_ready),
        .tx_level_i(tx_level_i), .tx_start_ok_o(tx_start_ok_o),
        .tx_fifo_last_o(tx_fifo_last_o), .rx_fifo_first_o(rx_fifo_first_o),
        .rx_fifo_last_o(rx_fifo_last_o), .rx_ring_base_o(rx_ring_base_o));
    mrhf_sink u_sink (.mclk_i(mclk_i), .rst_i(rst_i), .stall_i(stall),
        .res_ready_o(res_ready));

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task complete_run;
        $display("Mismatches %0d, comparisons %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // A wait that runs out is a mismatch and ends the run at once.
    task bound(input int lim);
        if (n >= lim)
        begin
            fail_count++;
            $display("Error %0t: wait ran out", $time);
            complete_run();
        end
    endtask : bound

    // One APB transfer; an idle edge follows so psel is never redriven.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do @(posedge mclk_i); while (pready_o !== 1'b1 && ++n < 50);
        bound(50);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask : apb

    // Reference verdict: reflected CRC, top six bits index the table.
    function logic [8:0] model(input logic [47:0] da);
        logic [31:0] c;
        logic [63:0] tbl;
        logic [5:0]  h;
        logic        g, x;
        c = 32'hffffffff;
        for (int i = 5; i >= 0; i--)
        begin
            c ^= {24'h0, da[i*8+:8]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        h = c[31:26];
        g = da[40];
        x = !g && (da === stn);
        tbl = g ? {val[2], val[3]} : {val[0], val[1]};
        return {tbl[h] | x, g, x, h};
    endfunction : model

    task send(input logic [47:0] da);
        exp_q.push_back(model(da));
        for (int i = 5; i >= 0; i--)
        begin
            da_valid_i <= 1'b1;
            da_sof_i <= (i == 5);
            da_byte_i <= da[i*8+:8];
            n = 0;
            do @(posedge mclk_i); while (da_ready_o !== 1'b1 && ++n < 300);
            bound(300);
        end
        da_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask : send

    task drain;
        n = 0;
        while (exp_q.size() != 0 && ++n < 900)
            @(posedge mclk_i);
        bound(900);
    endtask : drain

    // Each popped verdict meets the model.
    always @(posedge mclk_i)
        if (res_valid_o === 1'b1 && res_ready === 1'b1)
            chk({res_accept_o, res_group_o, res_exact_o, res_hash_o},
                exp_q.size() ? exp_q.pop_front() : 9'h1ff);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h014, 32'hffffffff);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h000007fc);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h00000500);
        chk(tx_fifo_last_o, 11'h4fc);
        chk(rx_fifo_last_o, 11'h7fc);
        apb(1'b0, 12'h030, 32'h0);
        chk(er, 1'b1);
        // Legal splits: bit 10 set, start 0x48 or above.
        repeat (3)
        begin
            v = 32'h400 | (({$random(seed)} % 32'hee + 32'h12) << 2);
            apb(1'b1, 12'h018, v);
            apb(1'b0, 12'h018, 32'h0);
            chk(rd, v);
            chk(rx_fifo_first_o, v[10:0]);
            chk(tx_fifo_last_o, v[10:0] - 11'h004);
        end
        for (int i = 0; i < 7; i++)
        begin
            val[i] = $random(seed);
            if (i == 4)
                val[i] &= 32'hfffffffc;
            if (i == 5)
                val[i][24] = 1'b0;
            apb(1'b1, offs[i], val[i]);
        end
        stn = {val[5], val[6][31:16]};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, offs[i], 32'h0);
            chk(rd, i == 6 ? {val[6][31:16], 16'h8808} : val[i]);
        end
        chk(rx_ring_base_o, val[4]);
        for (int k = 0; k < 4; k++)
        begin
            t = k < 2 ? 11'h040 : (k == 2 ? 11'h080 : 11'h0c0);
            apb(1'b1, 12'h010, 32'(k));
            tx_level_i <= t - 11'h001;
            @(posedge mclk_i);
            chk(tx_start_ok_o, 1'b0);
            tx_level_i <= t;
            @(posedge mclk_i);
            chk(tx_start_ok_o, 1'b1);
        end
        send(stn);
        send(48'hffffffffffff);
        repeat (12)
            send({$random(seed), $random(seed)});
        drain();
        // Stalled consumer: four verdicts fill the buffer, a fifth waits.
        stall <= 1'b1;
        repeat (3) @(posedge mclk_i);
        repeat (5)
            send({$random(seed), $random(seed)});
        repeat (4) @(posedge mclk_i);
        chk(da_ready_o, 1'b0);
        chk(res_valid_o, 1'b1);
        stall <= 1'b0;
        drain();
        repeat (4) @(posedge mclk_i);
        chk(res_valid_o, 1'b0);
        chk(da_ready_o, 1'b1);
        // A second reset restores the split but leaves tables and ring.
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        chk(rx_fifo_first_o, 11'h500);
        chk(rx_ring_base_o, val[4]);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, val[1]);
        complete_run();
    end
endmodule : tb
